// File: design/dlas_scrambler_gate.sv
`timescale 1ns/1ps
// scrambler with hold during frame sync bits when no seed is fed
module dlas_scrambler_gate
  import dlas_pkg::*;
#(
  parameter int unsigned LEN = 23
)
(
  input  wire logic clk,       // clock
  input  wire logic srst,      // sync reset
  input  wire logic symStb,    // one pulse per symbol
  input  wire logic useSeed,   // feed all ones seed
  input  wire logic syncBit,   // frame sync bit present
  input  wire logic framedBit, // framed bit in
  output logic      lineBit    // scrambled bit out
);
  logic [LEN-1:0] state;
  logic           inBit;
  logic           scr;

  // seed is constant one
  assign inBit = useSeed ? 1'b1 : framedBit;
  assign scr   = inBit ^ state[LEN-1] ^ state[17];

  // scrambler state frozen on sync bits unless seed is fed
  always_ff @(posedge clk)
  begin
    if (srst)
      state <= '0;
    else if (symStb && !(syncBit && !useSeed))
      state <= {state[LEN-2:0], scr};
  end

  // output register, sync bits bypass unless seed is fed
  always_ff @(posedge clk)
  begin
    if (srst)
      lineBit <= 1'b0;
    else if (symStb)
      lineBit <= (syncBit && !useSeed) ? framedBit : scr;
  end
endmodule

// File: design/dlas_sequencer.sv
`timescale 1ns/1ps
// activation sequencer for both line side and customer side units
module dlas_sequencer
  import dlas_pkg::*;
#(
  parameter int unsigned SYM_HZ = SYM_HZ_DEF // symbol rate
)
(
  input  wire logic       clk,          // 40 MHz clock
  input  wire logic       srst,         // sync reset, high
  input  wire logic       isLineSide,   // 1 line side unit, 0 customer
  input  wire logic [4:0] rateIndex,    // payload rate index n
  input  wire logic       symStb,       // local symbol pulse
  input  wire logic       preactDone,   // preactivation finished pulse
  input  wire logic       peerSignal,   // far end energy present (pin)
  input  wire logic       converged,    // adaptive elements settled
  input  wire logic       detInitial,   // initial signal detected
  input  wire logic       detTrain,     // peer training frames detected
  input  wire logic       detFinal,     // final frames detected
  input  wire logic       abnormal,     // loop restart needed
  input  wire logic       frameEnd,     // last bit of activation frame
  input  wire logic       syncBit,      // framer emits sync bit
  input  wire logic       framedBit,    // framer bit
  output dlas_tx_e        txSignal,     // signal being sent
  output logic            lineBit,      // scrambled line bit
  output logic            reverseSync,  // framer reverses sync word
  output logic            arbPayload,   // framer sends arbitrary payload
  output logic            ignoreRxPay,  // drop received training payload
  output logic            loopTimed,    // lock to received clock
  output logic            payloadValid, // payload data valid
  output logic            restartPre,   // pulse to restart preactivation
  output logic            inException,  // exception state
  output logic            globalOver    // 30 s budget exceeded
);
  typedef enum logic [3:0]
  {
    S_IDLE,
    S_INIT_GAP,
    S_INITIAL,
    S_SYNC_GAP,
    S_SYNC,
    S_TRAIN,
    S_FINAL,
    S_DATA,
    S_QUIET,
    S_WAIT_PEER
  } dlas_state_e;

  // symbols for a time; nominal at symbol grain lies inside tolerance
  function automatic logic [TW-1:0] symFor(input int unsigned ms, input logic two);
    longint unsigned v;
    v = (longint'(ms) * SYM_HZ * (two ? 2 : 1)) / MS_PER_S;
    return (v == 0) ? TW'(1) : TW'(v);
  endfunction

  dlas_state_e    state;
  dlas_state_e    next_state;
  logic           factorTwo;
  logic [TW-1:0]  tmr;
  logic [TW-1:0]  actTmr;
  logic [TW-1:0]  glbTmr;
  logic [TW-1:0]  setTmr;
  logic [1:0]     finCnt;
  logic           actRun;
  logic           glbRun;
  logic           peerS1;
  logic           peerS2;
  logic           sawDet;
  logic           timeout;
  logic           seedSel;

  // rate factor from payload index
  assign factorTwo = (rateIndex <= 5'(RATE_SPLIT));

  // far end energy resync
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      peerS1 <= 1'b0;
      peerS2 <= 1'b0;
    end
    else
    begin
      peerS1 <= peerSignal;
      peerS2 <= peerS1;
    end
  end

  // activation timeout: 15 factor s from initial start
  assign timeout = actRun && (actTmr >= symFor(ACT_MAX_MS, factorTwo));

  // next state
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:
        if (preactDone)
          next_state = isLineSide ? S_SYNC_GAP : S_INIT_GAP;
      S_INIT_GAP:
        if (tmr >= symFor(INIT_GAP_MS, 1'b0))
          next_state = S_INITIAL;
      S_INITIAL:
        if (tmr >= symFor(INIT_LEN_MS, factorTwo))
          next_state = S_SYNC_GAP;
      S_SYNC_GAP:
        if (isLineSide)
        begin
          // wait for initial signal to end, then gap
          if (sawDet && !detInitial && tmr >= symFor(SYNC_GAP_LTU_MS, 1'b0))
            next_state = S_SYNC;
        end
        else if (tmr >= symFor(SYNC_GAP_NTU_MS, factorTwo))
          next_state = S_SYNC;
      S_SYNC:
        if (isLineSide)
        begin
          if (converged && tmr >= symFor(PULL_IN_MS, 1'b0))
            next_state = S_TRAIN;
        end
        else if (converged && detTrain)
          next_state = S_TRAIN;
      S_TRAIN:
        if (isLineSide)
        begin
          if (detTrain && frameEnd && symStb)
            next_state = S_FINAL;
        end
        else if (detFinal)
          next_state = S_DATA;
      S_FINAL:
        if (frameEnd && symStb && finCnt == 2'(FINAL_FRAMES - 1))
          next_state = S_DATA;
      S_DATA:
        next_state = S_DATA;
      S_QUIET:
        if (tmr >= symFor(QUIET_MS, 1'b0))
          next_state = S_WAIT_PEER;
      S_WAIT_PEER:
        if (!peerS2)
          next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
    // exception entry overrides progress
    if (state != S_IDLE && state != S_QUIET && state != S_WAIT_PEER)
    begin
      if (abnormal)
        next_state = S_QUIET;
      else if (state != S_DATA && timeout)
        next_state = S_QUIET;
      else if (state == S_SYNC && isLineSide && tmr >= symFor(PULL_IN_MS, 1'b0) && !converged)
        next_state = S_QUIET;
      else if (state == S_SYNC && !isLineSide && tmr >= symFor(PULL_IN_MS, 1'b0))
        next_state = (converged && detTrain) ? S_TRAIN : S_QUIET;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (srst)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // phase timer in symbols, restarts on state change and while the line side hears initial signal in sync gap
  always_ff @(posedge clk)
  begin
    if (srst || next_state != state || (state == S_SYNC_GAP && isLineSide && detInitial))
      tmr <= '0;
    else if (symStb && tmr != '1)
      tmr <= tmr + TW'(1);
  end

  // initial signal seen by the line side
  always_ff @(posedge clk)
  begin
    if (srst || state != S_SYNC_GAP)
      sawDet <= 1'b0;
    else if (detInitial)
      sawDet <= 1'b1;
  end

  // activation timer from initial start until data mode
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      actRun <= 1'b0;
      actTmr <= '0;
    end
    else if (next_state == S_QUIET || next_state == S_DATA || next_state == S_IDLE)
    begin
      actRun <= 1'b0;
      actTmr <= '0;
    end
    else if (state == S_SYNC_GAP && isLineSide && detInitial && !actRun)
      actRun <= 1'b1;
    else if (next_state == S_INITIAL && !actRun)
      actRun <= 1'b1;
    else if (actRun && symStb)
      actTmr <= actTmr + TW'(1);
  end

  // global 30 s budget, reported only
  always_ff @(posedge clk)
  begin
    if (srst || state == S_WAIT_PEER)
    begin
      glbRun     <= 1'b0;
      glbTmr     <= '0;
      globalOver <= 1'b0;
    end
    else
    begin
      if (state == S_IDLE && !glbRun)
        glbRun <= 1'b1;
      if (next_state == S_DATA)
        glbRun <= 1'b0;
      if (glbRun && symStb)
        glbTmr <= glbTmr + TW'(1);
      if (glbRun && glbTmr >= symFor(GLOBAL_MS, 1'b0))
        globalOver <= 1'b1;
    end
  end

  // final frame counter
  always_ff @(posedge clk)
  begin
    if (srst || state != S_FINAL)
      finCnt <= '0;
    else if (frameEnd && symStb)
      finCnt <= finCnt + 2'(1);
  end

  // payload settle timer from end of final frames, dropped when data mode ends
  always_ff @(posedge clk)
  begin
    if (srst || state != S_DATA || next_state != S_DATA)
    begin
      setTmr       <= '0;
      payloadValid <= 1'b0;
    end
    else if (setTmr >= symFor(SETTLE_MS, 1'b0))
      payloadValid <= 1'b1;
    else if (symStb)
      setTmr <= setTmr + TW'(1);
  end

  // transmit selection and framer controls
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txSignal    <= TX_SILENT;
      reverseSync <= 1'b0;
      arbPayload  <= 1'b0;
      ignoreRxPay <= 1'b0;
      loopTimed   <= 1'b0;
      inException <= 1'b0;
      restartPre  <= 1'b0;
    end
    else
    begin
      case (next_state)
        S_INITIAL:
          txSignal <= TX_INITIAL;
        S_SYNC:
          txSignal <= TX_SYNC;
        S_TRAIN:
          txSignal <= TX_TRAIN;
        S_FINAL:
          txSignal <= TX_FINAL;
        S_DATA:
          txSignal <= TX_DATA;
        default:
          txSignal <= TX_SILENT;
      endcase
      reverseSync <= (next_state == S_FINAL);
      arbPayload  <= (next_state == S_FINAL);
      if (next_state == S_FINAL)
        ignoreRxPay <= 1'b1;
      else if (next_state == S_IDLE)
        ignoreRxPay <= 1'b0;
      loopTimed   <= !isLineSide && (next_state == S_SYNC || next_state == S_TRAIN
                     || next_state == S_DATA);
      inException <= (next_state == S_QUIET || next_state == S_WAIT_PEER);
      restartPre  <= (state == S_WAIT_PEER && next_state == S_IDLE);
    end
  end

  assign seedSel = (txSignal == TX_INITIAL) || (txSignal == TX_SYNC);

  // line scrambler
  dlas_scrambler_gate u_scr
  (
    .clk       (clk),
    .srst      (srst),
    .symStb    (symStb),
    .useSeed   (seedSel),
    .syncBit   (syncBit),
    .framedBit (framedBit),
    .lineBit   (lineBit)
  );
endmodule

// File: include/dlas_pkg.sv
// constants and types for the activation sequencer
package dlas_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned SYM_HZ_DEF      = 40_000;
  // times in milliseconds as printed
  localparam int unsigned TOL_MS          = 20;
  localparam int unsigned INIT_GAP_MS     = 300;
  localparam int unsigned INIT_LEN_MS     = 1000;
  localparam int unsigned SYNC_GAP_LTU_MS = 500;
  localparam int unsigned SYNC_GAP_NTU_MS = 1500;
  localparam int unsigned ACT_MAX_MS      = 15000;
  localparam int unsigned GLOBAL_MS       = 30000;
  localparam int unsigned PULL_IN_MS      = 5000;
  localparam int unsigned SETTLE_MS       = 1000;
  localparam int unsigned QUIET_MS        = 2000;
  localparam int unsigned DATA_MAX_SYM    = 200;
  localparam int unsigned FINAL_FRAMES    = 2;
  localparam int unsigned RATE_SPLIT      = 12;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned TW              = 32;

  // transmit signal selector
  typedef enum logic [2:0]
  {
    TX_SILENT,
    TX_INITIAL,
    TX_SYNC,
    TX_TRAIN,
    TX_FINAL,
    TX_DATA
  } dlas_tx_e;
endpackage

// File: verification/dlas_peer_model.sv
// peer transceiver model at the far loop end
`timescale 1ns/1ps
module dlas_peer_model
  import dlas_pkg::*;
#(
  parameter int unsigned FR = 8 // symbols per frame
)
(
  input  wire logic     clk,        // clock
  input  wire logic     symStb,     // symbol pulse
  input  wire logic     good,       // peer cooperates
  input  wire logic     holdTalk,   // peer keeps sending, sends no final
  input  wire dlas_tx_e txSignal,   // local signal
  output logic          peerSignal, // far end energy
  output logic          converged,  // adaptive settled
  output logic          detTrain,   // training detected
  output logic          detFinal,   // final detected
  output logic          frameEnd,   // last frame bit
  output logic          syncBit,    // sync bit present
  output logic          framedBit   // framed bit
);
  logic [7:0] pos = 8'h00; // bit position in frame
  // frame position per symbol
  always @(posedge clk)
  begin
    if (symStb)
      pos <= (pos == 8'(FR - 1)) ? 8'h00 : pos + 8'h01;
  end
  // peer answers to what the local unit sends
  assign peerSignal = holdTalk || txSignal inside {TX_SYNC, TX_TRAIN, TX_FINAL, TX_DATA};
  assign converged  = good && txSignal inside {TX_SYNC, TX_TRAIN, TX_FINAL, TX_DATA};
  assign detTrain   = good && txSignal inside {TX_SYNC, TX_TRAIN};
  assign detFinal   = good && !holdTalk && txSignal == TX_TRAIN;
  assign frameEnd   = pos == 8'(FR - 1);
  assign syncBit    = pos < 8'h02;
  assign framedBit  = pos[0] ^ pos[2];
endmodule

// File: verification/dlas_seq_properties.sv
// property checker for the activation sequencer ports
`timescale 1ns/1ps
module dlas_seq_properties
  import dlas_pkg::*;
(
  input wire logic     clk,          // clock
  input wire logic     srst,         // sync reset
  input wire logic     isLineSide,   // unit side
  input wire logic     symStb,       // symbol pulse
  input wire logic     frameEnd,     // last frame bit
  input wire logic     syncBit,      // frame sync bit
  input wire logic     framedBit,    // framed bit
  input wire dlas_tx_e txSignal,     // signal sent
  input wire logic     lineBit,      // line bit
  input wire logic     reverseSync,  // reversed sync word
  input wire logic     arbPayload,   // arbitrary payload
  input wire logic     ignoreRxPay,  // drop rx payload
  input wire logic     loopTimed,    // loop timed
  input wire logic     payloadValid, // payload valid
  input wire logic     restartPre,   // restart pulse
  input wire logic     inException   // exception state
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // output flags tied to the signal being sent or the exception state
  AST_PV_DATA: assert property (payloadValid |-> txSignal == TX_DATA)
    else $error("payload valid outside data mode");
  AST_FINAL_FLAGS: assert property (txSignal == TX_FINAL |-> reverseSync && arbPayload)
    else $error("final frames without reversed sync or arbitrary payload");
  AST_IGNORE_RX: assert property (txSignal == TX_FINAL |-> ignoreRxPay)
    else $error("rx payload kept during final frames");
  AST_LOOP_TIMED: assert property (!isLineSide && txSignal inside {TX_SYNC, TX_TRAIN, TX_DATA} |-> loopTimed)
    else $error("customer side not loop timed");
  AST_EXC_SILENT: assert property (inException |-> txSignal == TX_SILENT)
    else $error("transmitting in exception state");
  AST_RESTART_PULSE: assert property (restartPre |-> $past(inException) ##1 !restartPre)
    else $error("restart pulse malformed");
  // transitions and scrambler bypass
  AST_FINAL_CONTIG: assert property ($rose(txSignal == TX_FINAL) |-> $past(txSignal) == TX_TRAIN && $past(frameEnd && symStb))
    else $error("final frames not contiguous with training");
  AST_SYNC_BYPASS: assert property (symStb && syncBit && txSignal inside {TX_TRAIN, TX_FINAL} |=> lineBit == $past(framedBit))
    else $error("sync bit scrambled");
  COV_DATA: cover property (txSignal == TX_DATA && payloadValid);
  COV_FINAL: cover property (txSignal == TX_FINAL);
  COV_RESTART: cover property (restartPre);
endmodule

bind dlas_sequencer dlas_seq_properties i_dlas_seq_properties
(
  .clk(clk), .srst(srst), .isLineSide(isLineSide), .symStb(symStb), .frameEnd(frameEnd),
  .syncBit(syncBit), .framedBit(framedBit), .txSignal(txSignal), .lineBit(lineBit),
  .reverseSync(reverseSync), .arbPayload(arbPayload), .ignoreRxPay(ignoreRxPay), .loopTimed(loopTimed),
  .payloadValid(payloadValid), .restartPre(restartPre), .inException(inException)
);

// File: verification/tb_top.sv
// testbench for the activation sequencer
`timescale 1ns/1ps
module tb_top;
  import dlas_pkg::*;
  localparam int unsigned SH = 100; // scaled symbol rate
  localparam int unsigned FR = 8;   // frame length
  logic       clk = 1'b0, srst = 1'b1, isLineSide = 1'b0, symStb = 1'b0, preactDone = 1'b0;
  logic       detInitial = 1'b0, abnormal = 1'b0, good = 1'b1, holdTalk = 1'b0;
  logic [4:0] rateIndex = 5'h0d;
  logic [1:0] div = 2'h0;
  logic       peerSignal, converged, detTrain, detFinal, frameEnd, syncBit, framedBit;
  logic       lineBit, reverseSync, arbPayload, ignoreRxPay, loopTimed, payloadValid, restartPre, inException;
  logic       globalOver;
  dlas_tx_e   txSignal;
  int         err_count = 0, comparisons = 0, symTotal = 0;

  dlas_sequencer #(.SYM_HZ(SH)) i_dlas_sequencer
  (
    .clk(clk), .srst(srst), .isLineSide(isLineSide), .rateIndex(rateIndex), .symStb(symStb),
    .preactDone(preactDone), .peerSignal(peerSignal), .converged(converged), .detInitial(detInitial),
    .detTrain(detTrain), .detFinal(detFinal), .abnormal(abnormal), .frameEnd(frameEnd), .syncBit(syncBit),
    .framedBit(framedBit), .txSignal(txSignal), .lineBit(lineBit), .reverseSync(reverseSync),
    .arbPayload(arbPayload), .ignoreRxPay(ignoreRxPay), .loopTimed(loopTimed), .payloadValid(payloadValid),
    .restartPre(restartPre), .inException(inException), .globalOver(globalOver)
  );
  dlas_peer_model #(.FR(FR)) i_dlas_peer_model
  (
    .clk(clk), .symStb(symStb), .good(good), .holdTalk(holdTalk), .txSignal(txSignal),
    .peerSignal(peerSignal), .converged(converged), .detTrain(detTrain), .detFinal(detFinal),
    .frameEnd(frameEnd), .syncBit(syncBit), .framedBit(framedBit)
  );
  // clock and symbol pulse every fourth cycle
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk)
  begin
    div <= div + 2'h1;
    symStb <= div == 2'h3;
  end
  always @(posedge clk)
  begin
    if (symStb)
      symTotal <= symTotal + 1;
  end
  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // count compare within a tolerance of symbols
  task automatic chk(input int got, input int exp, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // symbols until the signal sent matches
  task automatic wait_tx(input dlas_tx_e v, output int n);
    int s;
    s = symTotal;
    while (txSignal !== v && symTotal - s < 4000)
      @(negedge clk);
    n = symTotal - s;
    if (txSignal !== v)
      chk(0, 1, 0);
  endtask
  // reset then end of preactivation
  task automatic start(input logic side, input logic [4:0] n);
    isLineSide <= side;
    rateIndex <= n;
    srst <= 1'b1;
    repeat (2) @(negedge clk);
    srst <= 1'b0;
    @(negedge clk);
    preactDone <= 1'b1;
    @(negedge clk);
    preactDone <= 1'b0;
  endtask
  task automatic t_customer(input logic [4:0] n);
    int f, d;
    f = n > 5'h0c ? 1 : 2;
    start(1'b0, n);
    wait_tx(TX_INITIAL, d);
    chk(d, 30, 2);
    wait_tx(TX_SILENT, d);
    chk(d, 100 * f, 2);
    wait_tx(TX_SYNC, d);
    chk(d, 150 * f, 2);
    wait_tx(TX_DATA, d);
    d = symTotal;
    while (payloadValid !== 1'b1 && symTotal - d < 400)
      @(negedge clk);
    chk(symTotal - d, SH, 2);
  endtask
  task automatic t_abnormal();
    int d;
    abnormal <= 1'b1;
    @(negedge clk);
    abnormal <= 1'b0;
    chkb(inException, 1'b1);
    d = symTotal;
    while (restartPre !== 1'b1 && symTotal - d < 900)
      @(negedge clk);
    chk(symTotal - d, 200, 2);
  endtask
  task automatic t_line();
    int d;
    start(1'b1, 5'h0d);
    detInitial <= 1'b1;
    repeat (40) @(negedge clk);
    detInitial <= 1'b0;
    wait_tx(TX_SYNC, d);
    chk(d, 50, 2);
    wait_tx(TX_TRAIN, d);
    chk(d, 500, 2);
    wait_tx(TX_FINAL, d);
    wait_tx(TX_DATA, d);
    chk(d, 2 * FR, 1);
  endtask
  // line side never hears the peer; budget flag after 30 s of symbols
  task automatic t_global();
    int d;
    start(1'b1, 5'h0d);
    d = symTotal;
    while (globalOver !== 1'b1 && symTotal - d < 3100)
      @(negedge clk);
    chk(symTotal - d, 3000, 2);
  endtask
  // peer never shows final frames; activation limit of 15 s from initial start
  task automatic t_timeout();
    int d;
    holdTalk <= 1'b1;
    start(1'b0, 5'h0d);
    wait_tx(TX_INITIAL, d);
    d = symTotal;
    while (inException !== 1'b1 && symTotal - d < 1700)
      @(negedge clk);
    chk(symTotal - d, 1500, 2);
    holdTalk <= 1'b0;
  endtask
  task automatic t_nosync();
    int d;
    good <= 1'b0;
    start(1'b0, 5'h0d);
    wait_tx(TX_SYNC, d);
    holdTalk <= 1'b1;
    d = symTotal;
    while (inException !== 1'b1 && symTotal - d < 900)
      @(negedge clk);
    chk(symTotal - d, 500, 2);
    repeat (1200) @(negedge clk);
    chkb(inException, 1'b1);
    holdTalk <= 1'b0;
    repeat (8) @(negedge clk);
    chkb(inException, 1'b0);
    good <= 1'b1;
  endtask
  // main sequence
  initial
  begin
    t_customer(5'h0d);
    t_abnormal();
    t_customer(5'h0c);
    t_line();
    t_global();
    t_timeout();
    t_nosync();
    print_verdict();
  end
  // watchdog, about twice the expected run of some 7500 symbols
  initial
  begin
    #1500000;
    err_count++;
    print_verdict();
  end
endmodule
